// File: pkg/gpedc_pkg.sv
// gpedc_pkg: register map, reset values and pin bundle type
// assumes a 32-bit apb slave with word-aligned registers
package gpedc_pkg;

	localparam int unsigned NUM_PINS = 16;

	// byte offsets within the block
	localparam logic [31:0] PIN_FUNCTION_ENABLE_OFS  = 32'h01B0_0000;
	localparam logic [31:0] PIN_DIRECTION_SELECT_OFS = 32'h01B0_0004;

	// reset values
	localparam logic [15:0] ENABLE_RST    = 16'h00F9;
	localparam logic [15:0] DIRECTION_RST = 16'h0000;

	// pin pad bundle toward the pads
	typedef struct packed {
		logic [15:0] out;
		logic [15:0] oe;
	} gpedc_pad_t;

endpackage

// File: rtl/gpedc_top.sv
// gpedc_top: apb-mapped enable and direction registers for sixteen pins
// assumes pclk domain apb master; pad inputs arrive asynchronously
// What this block does
// - a pin is under general-purpose control only while its enable bit is one.
// - an enabled pin whose direction bit is zero is an input and is not driven.
// - an enabled pin whose direction bit is one is driven as an output.
// - a direction bit has no effect on a pin whose enable bit is clear.
// - sixteen pins 15 to 0, bit x of both registers controlling pin x.
// - enable resets to bits 0,3,4,5,6,7 set, others clear, all read/write.
// - direction resets to all zero so all pins start as inputs, read/write.
`timescale 1ns/1ps
module gpedc_top #(
	parameter int unsigned WIDTH = gpedc_pkg::NUM_PINS
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [WIDTH-1:0]     general_pins_in,
	input  wire logic [WIDTH-1:0]     pin_out_value,
	output gpedc_pkg::gpedc_pad_t     general_pins_pad,
	output logic      [WIDTH-1:0]     general_pins_sync,
	output logic      [WIDTH-1:0]     pin_function_enable
);

	// assembled register words, one flip-flop per bit below
	logic [15:0] enable_r;
	logic [15:0] dir_r;

	// read data register
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;

	// synchronised pad inputs
	logic [15:0] sync2_r;

	// decode and handshake
	logic        sel_en;
	logic        sel_dir;
	logic        mapped;
	logic        setup;
	logic        access;
	logic        wr;
	logic        rd;

	// byte-lane write strobes, lane 0 is bits 7:0
	logic [1:0]  lane_wr_en;
	logic [1:0]  lane_wr_dir;

	// read multiplexer and drive mask
	logic [15:0] read_word;
	logic [15:0] drive_mask;

	// full 32-bit address match
	assign sel_en  = (paddr == gpedc_pkg::PIN_FUNCTION_ENABLE_OFS);
	assign sel_dir = (paddr == gpedc_pkg::PIN_DIRECTION_SELECT_OFS);
	assign mapped  = sel_en | sel_dir;

	// apb phases
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign wr      = access & pwrite;
	assign rd      = setup & ~pwrite;

	// zero-wait answer; unmapped access reports an error
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	// lanes 2 and 3 hold only reserved bits
	always_comb begin
		lane_wr_en  = 2'b00;
		lane_wr_dir = 2'b00;
		if (wr && sel_en) begin
			lane_wr_en = pstrb[1:0];
		end
		if (wr && sel_dir) begin
			lane_wr_dir = pstrb[1:0];
		end
	end

	// per-pin state: enable, direction and input synchroniser
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_bit
			logic en_bit_r;
			logic en_bit_nxt;
			logic dir_bit_r;
			logic dir_bit_nxt;
			logic sync1_bit_r;
			logic sync1_bit_nxt;
			logic sync2_bit_r;
			logic sync2_bit_nxt;

			// next config bits from the lane that holds this bit
			always_comb begin
				en_bit_nxt  = en_bit_r;
				dir_bit_nxt = dir_bit_r;
				if (lane_wr_en[g/8]) begin
					en_bit_nxt = pwdata[g];
				end
				if (lane_wr_dir[g/8]) begin
					dir_bit_nxt = pwdata[g];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					en_bit_r  <= gpedc_pkg::ENABLE_RST[g];
					dir_bit_r <= gpedc_pkg::DIRECTION_RST[g];
				end else begin
					en_bit_r  <= en_bit_nxt;
					dir_bit_r <= dir_bit_nxt;
				end
			end

			// two-stage synchroniser, only stage two is read
			always_comb begin
				sync1_bit_nxt = general_pins_in[g];
				sync2_bit_nxt = sync1_bit_r;
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1_bit_r <= 1'b0;
					sync2_bit_r <= 1'b0;
				end else begin
					sync1_bit_r <= sync1_bit_nxt;
					sync2_bit_r <= sync2_bit_nxt;
				end
			end

			assign enable_r[g] = en_bit_r;
			assign dir_r[g]    = dir_bit_r;
			assign sync2_r[g]  = sync2_bit_r;
		end
	endgenerate

	// low half of the addressed register, zero when unmapped
	always_comb begin
		read_word = 16'h0000;
		if (sel_en) begin
			read_word = enable_r;
		end else if (sel_dir) begin
			read_word = dir_r;
		end
	end

	// read data captured in setup, upper half reserved
	always_comb begin
		prdata_nxt = prdata_r;
		if (rd) begin
			prdata_nxt = {16'h0000, read_word};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata = prdata_r;

	// driven only when enabled and set as output
	assign drive_mask = enable_r & dir_r;

	genvar p;
	generate
		for (p = 0; p < WIDTH; p++) begin : g_pin
			assign general_pins_pad.oe[p]  = drive_mask[p];
			assign general_pins_pad.out[p] = drive_mask[p]
				& pin_out_value[p];
			assign general_pins_sync[p]    = enable_r[p]
				& sync2_r[p];
		end
	endgenerate

	assign pin_function_enable = enable_r;

endmodule

// File: verification/gpedc_chk_sva.sv
// checker on gpedc_top ports
// bound to every gpedc_top
`timescale 1ns/1ps
module gpedc_chk (
	input wire logic        pclk, presetn, psel, penable, pwrite,
	input wire logic [31:0] paddr, pwdata, prdata,
	input wire logic [3:0]  pstrb,
	input wire logic [15:0] pin_out_value, pin_function_enable,
	input gpedc_pkg::gpedc_pad_t general_pins_pad
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [15:0] oe = general_pins_pad.oe;
	wire [15:0] po = general_pins_pad.out;
	wire [15:0] en = pin_function_enable;
	wire w = psel & penable & pwrite & (pstrb == 4'hF);
	wire we = w & (paddr == 32'h01B0_0000);
	wire wd = w & (paddr == 32'h01B0_0004);
	property p_oe; (oe & ~en) == 0; endproperty
	a_oe: assert property (p_oe) else $error("oe off");
	property p_in; (po & ~oe) == 0; endproperty
	a_in: assert property (p_in) else $error("in");
	property p_drv; po == (oe & pin_out_value); endproperty
	a_drv: assert property (p_drv) else $error("drv");
	property p_d1; wd && pwdata[15:0] == 16'hFFFF ##1 !we |-> oe == en;
	endproperty
	a_d1: assert property (p_d1) else $error("dir1");
	property p_d0; wd && pwdata[15:0] == 0 |=> oe == 0; endproperty
	a_d0: assert property (p_d0) else $error("dir0");
	property p_ew; we |=> en == $past(pwdata[15:0]); endproperty
	a_ew: assert property (p_ew) else $error("en wr");
	property p_eh; !we |=> $stable(en); endproperty
	a_eh: assert property (p_eh) else $error("en hold");
	property p_hi; psel && !pwrite |-> prdata[31:16] == 0; endproperty
	a_hi: assert property (p_hi) else $error("hi");
	cover property (we);
	cover property (wd);
	cover property (oe != 0);
endmodule
bind gpedc_top gpedc_chk u_chk (.*);

// File: verification/gpedc_pins.sv
// pin partner: drives pads the block leaves
// assumes oe high while the block drives
`timescale 1ns/1ps
module gpedc_pins (
	input gpedc_pkg::gpedc_pad_t pad,
	input wire logic [15:0]      ext,
	output logic [15:0]          pin_in
);
	assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext);
endmodule

// File: verification/gpio_enable_direction_config_tb_top.sv
// bench for gpedc_top with pin partner
// model holds enable and direction words
`timescale 1ns/1ps
module gpio_enable_direction_config_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, w;
	logic [31:0] paddr = 0, pwdata = 0, prdata, d, r, e;
	logic [15:0] pv = 0, ext = 0, pin_in, en = 16'h00F9, dir = 0;
	logic pready, pslverr;
	logic [15:0] sync;
	gpedc_pkg::gpedc_pad_t pad;
	int mismatches = 0, n_tests = 0, k;
	gpedc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
		.general_pins_in(pin_in), .pin_out_value(pv),
		.general_pins_pad(pad), .general_pins_sync(sync),
		.pin_function_enable());
	gpedc_pins u_pins (.pad, .ext, .pin_in);
	initial forever #2 pclk = ~pclk;
	task chk(string s, logic [31:0] x, v);
		n_tests++;
		if (v !== x) begin
			mismatches++;
			$display("wrong value %s exp %h got %h", s, x, v);
		end
	endtask
	task complete_run;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h8B1B));
		repeat (4) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 60; i++) begin
			@(posedge pclk);
			k = i < 3 ? i : $urandom % 3;
			w = i > 2 && $urandom % 2;
			d = $urandom;
			psel <= 1; pwrite <= w; pwdata <= d;
			paddr <= 32'h01B0_0000 + k * 4;
			@(posedge pclk) penable <= 1;
			do @(posedge pclk); while (pready !== 1'b1);
			r = prdata;
			chk("err", {31'h0, k == 2}, {31'h0, pslverr});
			psel <= 0; penable <= 0; pv <= $urandom; ext <= $urandom;
			e = k == 0 ? en : k == 1 ? dir : 0;
			if (w && k == 0) en = d[15:0];
			if (w && k == 1) dir = d[15:0];
			if (!w) chk("rd", e, r);
			@(posedge pclk);
			chk("oe", {16'h0, en & dir}, {16'h0, pad.oe});
			chk("out", {16'h0, en & dir & pv}, {16'h0, pad.out});
			repeat (2) @(posedge pclk);
			chk("sync",
				{16'h0, en & ((en & dir & pv) | (~(en & dir) & ext))},
				{16'h0, sync});
		end
		complete_run();
	end
	initial begin
		#40000;
		mismatches++;
		complete_run();
	end
endmodule
